// [hdl/mtf_pkg.sv]
// Constants and types for the MODBUS TCP server frame engine.
// Assumes one 40 MHz clock and a byte stream with valid/ready on each side.
//
// What this block does
// - Transmit only as a reply to a received query; never originate.
// - Answer every good query whatever its unit id; unit 00 is not treated as broadcast.
// - Frame is 7-byte header: transaction, protocol, length, unit; then PDU.
// - Transaction identifier copied unchanged into the response.
// - Protocol identifier must be zero; received value is echoed back.
// - Length counts unit id, function code and data; recomputed per response.
// - Unit identifier returned exactly as received.
// - Multi-byte fields are sent most significant byte first.
// - Exception reply is function code plus 80 hex, then one code byte.
// - PDU never longer than 253 bytes either way.
// - Whole frame never longer than 260 bytes.
// - Requests are accepted on TCP port 502.
// - Variable-length PDUs carry a byte count so the end is known.
// - Fixed-length PDUs end is known from the function code alone.
// - No serial address byte and no CRC travel in the frame.
// - Function code zero invalid; 128 to 255 never valid as requests.
package mtf_pkg;

  localparam int unsigned HDR_BYTES = 7;
  localparam int unsigned PDU_MAX = 253;
  localparam int unsigned ADU_MAX = 260;
  localparam logic [15:0] TCP_PORT = 16'h01F6;
  localparam logic [15:0] PROTO_MODBUS = 16'h0000;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] UNIT_BROADCAST = 8'h00;
  localparam logic [7:0] UNIT_DIRECT = 8'hFF;
  localparam logic [2:0] IDX_TID_HI = 3'h0;
  localparam logic [2:0] IDX_TID_LO = 3'h1;
  localparam logic [2:0] IDX_PID_HI = 3'h2;
  localparam logic [2:0] IDX_PID_LO = 3'h3;
  localparam logic [2:0] IDX_LEN_HI = 3'h4;
  localparam logic [2:0] IDX_LEN_LO = 3'h5;
  localparam logic [2:0] IDX_UNIT = 3'h6;
  localparam logic [7:0] FC_MIN = 8'h01;
  localparam logic [7:0] FC_RESERVED = 8'h80;

  typedef enum logic [2:0] {
    MTF_IDLE = 3'b000,
    MTF_RX = 3'b001,
    MTF_WAIT = 3'b010,
    MTF_TX_HDR = 3'b011,
    MTF_TX_PDU = 3'b100,
    MTF_DROP = 3'b101
  } mtf_state_type;

endpackage

// [hdl/mtf_be_field.sv]
// Big-endian 16-bit field serialiser: picks high or low byte.
// Assumes the caller holds the field stable while it is being sent.
`timescale 1ns/1ps
`default_nettype none
module mtf_be_field (
  // Field and byte select
  input wire logic [15:0] field,
  input wire logic lo_sel,
  // Selected byte
  output logic [7:0] byte_out
);
  // High byte goes first on the wire
  assign byte_out = lo_sel ? field[7:0] : field[15:8];
endmodule
`default_nettype wire

// [hdl/mtf_framer.sv]
// MODBUS TCP server frame engine: parses request frames, emits responses.
// Assumes a TCP stack delivers payload bytes of one connection per port.
`timescale 1ns/1ps
`default_nettype none
module mtf_framer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Request byte stream from TCP stack
  input wire logic [15:0] rx_port,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_last,
  output logic rx_ready,
  // Parsed request toward function handler
  output logic [7:0] req_fc,
  output logic [7:0] req_data,
  output logic req_data_valid,
  output logic req_done,
  // Response PDU data from function handler
  input wire logic rsp_start,
  input wire logic rsp_exception,
  input wire logic [7:0] rsp_exc_code,
  input wire logic [7:0] rsp_pdu_len,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_data_valid,
  output logic rsp_data_ready,
  // Response byte stream to TCP stack
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_last,
  input wire logic tx_ready,
  // Status
  output logic frame_dropped
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    mtf_pkg::mtf_state_type st;
    logic [8:0] cnt;
    logic [15:0] tid;
    logic [15:0] pid;
    logic [15:0] len;
    logic [7:0] unit;
    logic [7:0] fc;
    logic [7:0] plen;
    logic exc;
    logic [7:0] exc_code;
    logic bad;
    logic rx_ready;
    logic [7:0] req_fc;
    logic [7:0] req_data;
    logic req_data_valid;
    logic req_done;
    logic rsp_data_ready;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_last;
    logic frame_dropped;
  } mtf_regs_type;

  mtf_regs_type q_r;
  mtf_regs_type q_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Header field serialisation

  logic [15:0] hdr_field;
  logic [15:0] rsp_len;
  logic [7:0] hdr_byte;
  logic [8:0] rx_total;

  // Response length: unit id, fc and data bytes
  assign rsp_len = q_r.exc ? 16'h0003 : (16'h0002 + {8'h00, q_r.plen});
  assign rx_total = q_r.cnt + 9'h001;

  always_comb begin
    case (q_r.cnt[2:1])
      2'h0: hdr_field = q_r.tid;
      2'h1: hdr_field = q_r.pid;
      default: hdr_field = rsp_len;
    endcase
  end

  mtf_be_field u_field (
    .field(hdr_field),
    .lo_sel(q_r.cnt[0]),
    .byte_out(hdr_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    q_nxt = q_r;
    q_nxt.req_data_valid = 1'b0;
    q_nxt.req_done = 1'b0;
    q_nxt.frame_dropped = 1'b0;
    q_nxt.rsp_data_ready = 1'b0;
    case (q_r.st)
      mtf_pkg::MTF_IDLE: begin
        q_nxt.rx_ready = 1'b1;
        q_nxt.tx_valid = 1'b0;
        q_nxt.tx_last = 1'b0;
        q_nxt.cnt = 9'h000;
        q_nxt.bad = 1'b0;
        // Ready and receive state move together so no offered byte is lost
        q_nxt.st = mtf_pkg::MTF_RX;
      end
      mtf_pkg::MTF_RX: begin
        if (rx_valid && q_r.rx_ready) begin
          q_nxt.cnt = rx_total;
          // Only port 502 traffic is served
          if (rx_port != mtf_pkg::TCP_PORT) begin
            q_nxt.bad = 1'b1;
          end
          // Header fields arrive high byte first
          case (q_r.cnt)
            {6'h00, mtf_pkg::IDX_TID_HI}: q_nxt.tid[15:8] = rx_data;
            {6'h00, mtf_pkg::IDX_TID_LO}: q_nxt.tid[7:0] = rx_data;
            {6'h00, mtf_pkg::IDX_PID_HI}: q_nxt.pid[15:8] = rx_data;
            {6'h00, mtf_pkg::IDX_PID_LO}: q_nxt.pid[7:0] = rx_data;
            {6'h00, mtf_pkg::IDX_LEN_HI}: q_nxt.len[15:8] = rx_data;
            {6'h00, mtf_pkg::IDX_LEN_LO}: q_nxt.len[7:0] = rx_data;
            {6'h00, mtf_pkg::IDX_UNIT}: q_nxt.unit = rx_data;
            9'h007: begin
              q_nxt.fc = rx_data;
              q_nxt.req_fc = rx_data;
            end
            default: begin
              // PDU data handed on; handler finds the end by code or count
              q_nxt.req_data = rx_data;
              q_nxt.req_data_valid = 1'b1;
            end
          endcase
          // Oversize frames are refused
          if (rx_total > 9'(mtf_pkg::ADU_MAX)) begin
            q_nxt.bad = 1'b1;
          end
          if (rx_last) begin
            q_nxt.rx_ready = 1'b0;
            // Bad protocol id or length mismatch: silent discard
            if (q_nxt.bad || q_nxt.pid != mtf_pkg::PROTO_MODBUS ||
                rx_total < 9'h008 ||
                q_nxt.len != 16'(rx_total - 9'(mtf_pkg::HDR_BYTES - 1)) ||
                rx_total - 9'(mtf_pkg::HDR_BYTES) > 9'(mtf_pkg::PDU_MAX)) begin
              q_nxt.st = mtf_pkg::MTF_DROP;
            end else if (q_nxt.fc < mtf_pkg::FC_MIN ||
                         q_nxt.fc >= mtf_pkg::FC_RESERVED) begin
              // Invalid code answered locally as exception
              q_nxt.exc = 1'b1;
              q_nxt.exc_code = mtf_pkg::EXC_ILLEGAL_FUNC;
              q_nxt.cnt = 9'h000;
              q_nxt.st = mtf_pkg::MTF_TX_HDR;
            end else begin
              // Unit 00 is direct over TCP, so every good query is answered
              q_nxt.req_done = 1'b1;
              q_nxt.st = mtf_pkg::MTF_WAIT;
            end
          end
        end
      end
      mtf_pkg::MTF_WAIT: begin
        // Reply only once the handler answers this query
        if (rsp_start) begin
          q_nxt.exc = rsp_exception;
          q_nxt.exc_code = rsp_exc_code;
          // Fc is one of the PDU bytes, so data stops one short of the limit
          q_nxt.plen = (rsp_pdu_len > 8'(mtf_pkg::PDU_MAX - 1)) ?
                       8'(mtf_pkg::PDU_MAX - 1) : rsp_pdu_len;
          q_nxt.cnt = 9'h000;
          q_nxt.st = mtf_pkg::MTF_TX_HDR;
        end
      end
      mtf_pkg::MTF_TX_HDR: begin
        if (!q_r.tx_valid || tx_ready) begin
          q_nxt.tx_valid = 1'b1;
          q_nxt.tx_last = 1'b0;
          // No serial address or CRC: header then PDU only
          if (q_r.cnt[2:0] == mtf_pkg::IDX_UNIT) begin
            q_nxt.tx_data = q_r.unit;
            q_nxt.cnt = 9'h000;
            q_nxt.st = mtf_pkg::MTF_TX_PDU;
          end else begin
            q_nxt.tx_data = hdr_byte;
            q_nxt.cnt = q_r.cnt + 9'h001;
          end
        end
      end
      mtf_pkg::MTF_TX_PDU: begin
        if (q_r.tx_valid && tx_ready && q_r.tx_last) begin
          q_nxt.tx_valid = 1'b0;
          q_nxt.tx_last = 1'b0;
          q_nxt.exc = 1'b0;
          q_nxt.st = mtf_pkg::MTF_IDLE;
        end else if (!q_r.tx_valid || tx_ready) begin
          if (q_r.cnt == 9'h000) begin
            q_nxt.tx_valid = 1'b1;
            q_nxt.tx_data = q_r.exc ? (q_r.fc | mtf_pkg::EXC_FLAG) : q_r.fc;
            q_nxt.tx_last = !q_r.exc && q_r.plen == 8'h00;
            q_nxt.cnt = 9'h001;
          end else if (q_r.exc) begin
            q_nxt.tx_valid = 1'b1;
            q_nxt.tx_data = q_r.exc_code;
            q_nxt.tx_last = 1'b1;
          end else if (rsp_data_valid && q_r.rsp_data_ready) begin
            q_nxt.tx_valid = 1'b1;
            q_nxt.tx_data = rsp_data;
            q_nxt.tx_last = q_r.cnt == {1'b0, q_r.plen};
            q_nxt.cnt = q_r.cnt + 9'h001;
          end else begin
            q_nxt.tx_valid = 1'b0;
            q_nxt.rsp_data_ready = 1'b1;
          end
        end
      end
      mtf_pkg::MTF_DROP: begin
        q_nxt.frame_dropped = 1'b1;
        q_nxt.st = mtf_pkg::MTF_IDLE;
      end
      default: begin
        q_nxt.st = mtf_pkg::MTF_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign rx_ready = q_r.rx_ready;
  assign req_fc = q_r.req_fc;
  assign req_data = q_r.req_data;
  assign req_data_valid = q_r.req_data_valid;
  assign req_done = q_r.req_done;
  assign rsp_data_ready = q_r.rsp_data_ready;
  assign tx_data = q_r.tx_data;
  assign tx_valid = q_r.tx_valid;
  assign tx_last = q_r.tx_last;
  assign frame_dropped = q_r.frame_dropped;

endmodule
`default_nettype wire

// [verification/mtf_checker.sv]
// Port assertions for the frame engine.
// Assumes one clock; bound to mtf_framer below.
`timescale 1ns/1ps
`default_nettype none
module mtf_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Request side
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic rx_ready,
  input wire logic req_done,
  input wire logic rsp_start,
  // Reply side
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic tx_ready,
  input wire logic rsp_data_ready,
  input wire logic frame_dropped
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  AST_REPLY_ONLY: assert property (tx_valid |-> !rx_ready)
    else $error("tx while taking requests");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("tx byte moved");
  AST_DONE_CAUSE: assert property (req_done |-> $past(rx_valid && rx_ready && rx_last))
    else $error("done without last byte");
  AST_LAST_BLOCKS: assert property (rx_valid && rx_ready && rx_last |=> !rx_ready)
    else $error("ready after last byte");
  AST_DROP_SILENT: assert property (frame_dropped |-> !tx_valid ##1 !tx_valid)
    else $error("tx after drop");
  AST_DONE_PULSE: assert property (req_done |=> !req_done)
    else $error("done not a pulse");
  AST_RESET_CLEAR: assert property ($past(srst) |-> !tx_valid && !req_done && !rx_ready)
    else $error("outputs live after reset");
  AST_TX_CAUSE: assert property ($rose(tx_valid) && !$past(rsp_data_ready) |->
    $past(rsp_start, 2) || $past(rx_valid && rx_ready && rx_last, 2))
    else $error("tx unprompted");
endmodule
bind mtf_framer mtf_checker chk_u (.clk_sys(clk_sys), .srst(srst), .rx_valid(rx_valid),
  .rx_last(rx_last), .rx_ready(rx_ready), .req_done(req_done), .rsp_start(rsp_start),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
  .rsp_data_ready(rsp_data_ready), .frame_dropped(frame_dropped));
`default_nettype wire

// [verification/mtf_client.sv]
// Client model: sends request frames, collects reply bytes.
// Assumes the bench calls send and reads got between frames.
`timescale 1ns/1ps
`default_nettype none
module mtf_client (
  // Clock and pace
  input wire logic clk_sys,
  input wire logic slow,
  // Request stream
  output logic [15:0] rx_port,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_last,
  input wire logic rx_ready,
  // Reply stream
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [8:0] got[$];
  initial {rx_port, rx_data, rx_valid, rx_last, tx_ready} = '0;
  ////////////////////////////////////////
  // Stalls every other cycle when slow
  always @(negedge clk_sys) tx_ready <= slow ? !tx_ready : 1'b1;
  always @(posedge clk_sys) if (tx_valid && tx_ready) got.push_back({tx_last, tx_data});
  // Header high byte first, then fc and n data bytes
  task automatic send(input logic [15:0] tid, pid, port, len, input logic [7:0] unit, fc,
                      input int n);
    logic [7:0] f[$];
    f = '{tid[15:8], tid[7:0], pid[15:8], pid[7:0], len[15:8], len[7:0], unit, fc};
    for (int i = 0; i < n; i++) f.push_back(8'(i));
    foreach (f[k]) begin
      @(negedge clk_sys);
      rx_port <= port;
      {rx_valid, rx_last, rx_data} <= {1'b1, k == f.size() - 1, f[k]};
      do @(posedge clk_sys); while (!rx_ready);
    end
    @(negedge clk_sys);
    {rx_valid, rx_last} <= 2'b00;
    rx_data <= ~f[$]; // No stale byte once released
  endtask
endmodule
`default_nettype wire

// [verification/test_mtf_framer.sv]
// Bench for the frame engine; the handler side lives here.
// Assumes package, design and client model compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_mtf_framer;
  typedef struct {int pid, port, fc, code, n, adj, plen, exc, drop;} mtf_row_type;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic slow = 1'b0;
  logic rsp_start = 1'b0;
  logic rsp_exception = 1'b0;
  logic rsp_data_valid = 1'b1;
  logic [7:0] rsp_exc_code = 8'h00;
  logic [7:0] rsp_pdu_len = 8'h00;
  logic [7:0] rsp_data = 8'h00;
  logic [15:0] rx_port;
  logic [7:0] rx_data, tx_data;
  logic [7:0] req_fc, req_data;
  logic req_data_valid;
  logic [7:0] rq[$];
  int n_done = 0;
  logic rx_valid, rx_last, rx_ready, req_done, rsp_data_ready;
  logic tx_valid, tx_last, tx_ready, frame_dropped;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int idx = 0;
  int n_drop = 0;
  // pid, port, fc, code, n, adj, plen, exc, drop
  mtf_row_type rows[11] = '{
    '{0, 502, 3, 0, 4, 0, 5, 0, 0}, '{0, 502, 4, 0, 4, 0, 0, 0, 0},
    '{0, 502, 3, 2, 4, 0, 0, 1, 0}, '{0, 502, 0, 1, 4, 0, 0, 1, 0},
    '{0, 502, 133, 1, 4, 0, 0, 1, 0}, '{0, 503, 3, 0, 4, 0, 0, 0, 1},
    '{1, 502, 3, 0, 4, 0, 0, 0, 1}, '{0, 502, 3, 0, 4, 1, 0, 0, 1},
    '{0, 502, 3, 0, 252, 0, 252, 0, 0}, '{0, 502, 3, 0, 253, 0, 0, 0, 1},
    '{0, 502, 3, 0, 4, 0, 255, 0, 0}};
  mtf_framer dut_u (.clk_sys(clk_sys), .srst(srst), .rx_port(rx_port), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready), .req_fc(req_fc),
    .req_data(req_data), .req_data_valid(req_data_valid), .req_done(req_done),
    .rsp_start(rsp_start),
    .rsp_exception(rsp_exception), .rsp_exc_code(rsp_exc_code), .rsp_pdu_len(rsp_pdu_len),
    .rsp_data(rsp_data), .rsp_data_valid(rsp_data_valid), .rsp_data_ready(rsp_data_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .frame_dropped(frame_dropped));
  mtf_client cl_u (.clk_sys(clk_sys), .slow(slow), .rx_port(rx_port), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));
  always #12.5 clk_sys = !clk_sys;
  ////////////////////////////////////////
  // Handler answers one cycle after req_done; data counts up from A0
  always @(negedge clk_sys) begin
    rsp_start <= req_done;
    rsp_data <= 8'hA0 + 8'(idx);
    // Handler stalls on alternate cycles too when slow
    rsp_data_valid <= slow ? !rsp_data_valid : 1'b1;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (frame_dropped) n_drop <= n_drop + 1;
    if (req_done) n_done <= n_done + 1;
    if (req_data_valid) rq.push_back(req_data);
    idx <= rsp_start ? 0 : idx + int'(rsp_data_valid && rsp_data_ready);
    if (cyc == 30000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic run(input int r);
    mtf_row_type w;
    logic [15:0] tid, len;
    logic [7:0] unit;
    logic [7:0] e[$];
    int d0, d1, np, ok;
    w = rows[r];
    // Fc byte is one of the PDU bytes, so data is clipped one short
    np = w.plen > int'(mtf_pkg::PDU_MAX) - 1 ? int'(mtf_pkg::PDU_MAX) - 1 : w.plen;
    ok = int'(w.drop == 0 && w.fc >= 1 && w.fc < 128);
    tid = {8'(r + 1), 8'hC3};
    unit = r[0] ? 8'hFF : 8'h00;
    len = w.exc != 0 ? 16'h0003 : 16'(np + 2);
    @(negedge clk_sys);
    {rsp_exception, rsp_exc_code, rsp_pdu_len} = {w.exc != 0, 8'(w.code), 8'(w.plen)};
    d0 = n_drop;
    d1 = n_done;
    cl_u.got.delete();
    rq.delete();
    cl_u.send(tid, 16'(w.pid), 16'(w.port), 16'(w.n + 2 + w.adj), unit, 8'(w.fc), w.n);
    for (int t = 0; t < 2000 && n_drop == d0; t++) begin
      @(posedge clk_sys);
      if (cl_u.got.size() > 0 && cl_u.got[$][8]) break;
    end
    repeat (20) @(posedge clk_sys);
    if (w.drop == 0) begin
      e = '{tid[15:8], tid[7:0], 8'h00, 8'h00, len[15:8], len[7:0], unit,
            8'(w.fc) | (w.exc != 0 ? 8'h80 : 8'h00)};
      if (w.exc != 0) e.push_back(8'(w.code));
      for (int i = 0; i < np; i++) e.push_back(8'hA0 + 8'(i));
    end
    chk("drop", 16'(n_drop - d0), 16'(w.drop));
    chk("done", 16'(n_done - d1), 16'(ok));
    chk("req_fc", 16'(req_fc), 16'(w.fc));
    chk("req_n", 16'(rq.size()), 16'(w.n));
    foreach (rq[i])
      chk("req_byte", 16'(rq[i]), 16'(i));
    chk("size", 16'(cl_u.got.size()), 16'(e.size()));
    foreach (e[i])
      if (i < cl_u.got.size())
        chk("byte", 16'(cl_u.got[i]), {7'h00, i == e.size() - 1, e[i]});
    $display("row %0d over", r);
  endtask
  initial begin
    repeat (20) @(negedge clk_sys);
    chk("rdy", 16'(rx_ready), 16'h0000);
    srst = 1'b0;
    for (int r = 0; r < 11; r++) run(r);
    // Second reset, then replies under stalls
    @(negedge clk_sys);
    srst = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("txv", 16'(tx_valid), 16'h0000);
    chk("rdy2", 16'(rx_ready), 16'h0000);
    $display("reset test over");
    srst = 1'b0;
    slow = 1'b1;
    run(0);
    run(8);
    end_of_test();
  end
endmodule
`default_nettype wire
